// File: design/bdsn_params.svh
// constants for the bar decode and serial number block
// assumes inclusion by the single design module only
`ifndef BDSN_PARAMS_SVH
`define BDSN_PARAMS_SVH
`define BDSN_CAP_ID          16'h0003
`define BDSN_CAP_VER         4'h1
`define BDSN_NEXT_NONE       12'h000
`define BDSN_NEXT_MIN        12'h0ff
`define BDSN_OFS_HDR         12'h000
`define BDSN_OFS_SN_LO       12'h004
`define BDSN_OFS_SN_HI       12'h008
`define BDSN_MAC_LABEL       16'hffff
`define BDSN_REG_SPAN        32'h0002_0000
`define BDSN_MSIX_SPAN       32'h0000_4000
`define BDSN_IO_SPAN         32'h0000_0020
`define BDSN_IO_ADDR_OFS     5'h00
`define BDSN_IO_DATA_OFS     5'h04
`define BDSN_IO_ADDR_MASK    32'h000f_ffff
`define BDSN_IO_RSVD_DATA    32'h0000_ffff
`define BDSN_FLASH_WIN_LO    20'h8_0000
`define BDSN_REGS_WIN_HI     20'h1_ffff
`endif

// File: design/bdsn_pkg.sv
// types for the bar decode and serial number block
// assumes nothing of its surroundings
package bdsn_pkg;
  typedef enum logic [2:0] {
    BDSN_TGT_NONE  = 3'h0,
    BDSN_TGT_REGS  = 3'h1,
    BDSN_TGT_FLASH = 3'h3,
    BDSN_TGT_MSIX  = 3'h2,
    BDSN_TGT_IOWIN = 3'h6
  } bdsn_target_t;
  typedef enum logic [1:0] {
    BDSN_SN_WAIT = 2'h0,
    BDSN_SN_HELD = 2'h1
  } bdsn_sn_state_t;
endpackage

// File: design/bdsn_bar_decode.sv
// address decode for the memory and i/o windows plus the serial number capability
// assumes the pcie core hands over one request per cycle on its own clock,
// and that bar values, command bits and the nvm load flag are stable core state
`timescale 1ns/10ps
`include "bdsn_params.svh"
module bdsn_bar_decode
  import bdsn_pkg::*;
#(
  parameter logic [11:0] NEXT_CAP_OFS = 12'h000,
  parameter logic [23:0] COMPANY_ID   = 24'h12_34_56, // arbitrary value
  parameter int          FLASH_AW     = 24,
  parameter int          ROM_AW       = 18
) (
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_b_in,
  // configuration state
  input  wire logic [31:0]        bar0_in,
  input  wire logic [31:0]        bar1_in,
  input  wire logic [31:0]        bar2_in,
  input  wire logic [31:0]        bar3_in,
  input  wire logic [31:0]        rom_bar_in,
  input  wire logic               io_enable_in,
  input  wire logic               flash_enable_in,
  input  wire logic               rom_enable_in,
  // mac address as loaded from nvm
  input  wire logic [31:0]        receive_address_low_in,
  input  wire logic [15:0]        receive_address_high_in,
  input  wire logic               nvm_load_done_in,
  // configuration read of the capability
  input  wire logic               cfg_rd_in,
  input  wire logic [11:0]        cfg_ofs_in,
  output logic                    cfg_valid_out,
  output logic [31:0]             cfg_data_out,
  // host request
  input  wire logic               req_in,
  input  wire logic               req_io_in,
  input  wire logic               req_wr_in,
  input  wire logic [31:0]        req_addr_in,
  input  wire logic [3:0]         req_be_in,
  input  wire logic [31:0]        req_wdata_in,
  output logic                    rsp_valid_out,
  output logic [31:0]             rsp_rdata_out,
  output logic                    rsp_hit_out,
  // internal access
  output logic                    int_req_out,
  output logic                    int_wr_out,
  output bdsn_target_t            int_target_out,
  output logic [23:0]             int_addr_out,
  output logic [3:0]              int_be_out,
  output logic [31:0]             int_wdata_out,
  input  wire logic               int_done_in,
  input  wire logic [31:0]        int_rdata_in,
  // indirect address register view
  output logic [31:0]             io_addr_out
);

  function automatic logic in_bar(input logic [31:0] addr, input logic [31:0] base,
                                  input logic [31:0] span);
    logic [31:0] diff;
    diff = addr - base;
    in_bar = (base != 32'h0) && (addr >= base) && (diff < span);
  endfunction

  function automatic logic [31:0] span_of(input int aw);
    span_of = 32'h1 << aw;
  endfunction

  bdsn_sn_state_t sn_state_q;
  logic [63:0]    serial_q;
  logic [31:0]    io_addr_q;
  logic [11:0]    next_ofs;
  logic [31:0]    hdr;

  // an illegal next offset would point into legacy space; end the list instead
  assign next_ofs = (NEXT_CAP_OFS > `BDSN_NEXT_MIN) ? NEXT_CAP_OFS : `BDSN_NEXT_NONE;
  assign hdr = {next_ofs, `BDSN_CAP_VER, `BDSN_CAP_ID};

  // latched once so later rewrites of the receive address cannot move it
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sn_state_q <= BDSN_SN_WAIT;
      serial_q   <= 64'h0;
    end else begin
      case (sn_state_q)
        BDSN_SN_WAIT: begin
          if (nvm_load_done_in) begin
            serial_q   <= {COMPANY_ID, `BDSN_MAC_LABEL,
                           receive_address_low_in[31:24], receive_address_high_in[7:0],
                           receive_address_high_in[15:8]};
            sn_state_q <= BDSN_SN_HELD;
          end
        end
        default: sn_state_q <= BDSN_SN_HELD;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cfg_valid_out <= 1'b0;
      cfg_data_out  <= 32'h0;
    end else begin
      cfg_valid_out <= cfg_rd_in;
      if (!cfg_rd_in) begin
        cfg_data_out <= 32'h0;
      end else if (cfg_ofs_in == `BDSN_OFS_HDR) begin
        cfg_data_out <= hdr;
      end else if (cfg_ofs_in == `BDSN_OFS_SN_LO) begin
        cfg_data_out <= serial_q[31:0];
      end else if (cfg_ofs_in == `BDSN_OFS_SN_HI) begin
        cfg_data_out <= serial_q[63:32];
      end else begin
        cfg_data_out <= 32'h0;
      end
    end
  end

  // decode of the incoming request
  logic         hit_regs;
  logic         hit_flash;
  logic         hit_rom;
  logic         hit_msix;
  logic         hit_io;
  logic [4:0]   io_ofs;
  logic [31:0]  ofs_regs;
  logic [31:0]  ofs_flash;
  logic [31:0]  ofs_rom;
  logic [31:0]  ofs_msix;
  logic         io_to_flash;
  logic         io_to_regs;

  assign hit_regs  = !req_io_in && in_bar(req_addr_in, bar0_in, `BDSN_REG_SPAN);
  assign hit_flash = !req_io_in && flash_enable_in &&
                     in_bar(req_addr_in, bar1_in, span_of(FLASH_AW));
  assign hit_rom   = !req_io_in && rom_enable_in &&
                     in_bar(req_addr_in, rom_bar_in, span_of(ROM_AW));
  assign hit_msix  = !req_io_in && in_bar(req_addr_in, bar3_in, `BDSN_MSIX_SPAN);
  assign hit_io    = req_io_in && io_enable_in &&
                     in_bar(req_addr_in, bar2_in, `BDSN_IO_SPAN);
  assign ofs_regs  = req_addr_in - bar0_in;
  assign ofs_flash = req_addr_in - bar1_in;
  assign ofs_rom   = req_addr_in - rom_bar_in;
  assign ofs_msix  = req_addr_in - bar3_in;
  assign io_ofs    = 5'(req_addr_in - bar2_in);
  assign io_to_flash = io_addr_q[19:0] >= `BDSN_FLASH_WIN_LO;
  assign io_to_regs  = io_addr_q[19:0] <= `BDSN_REGS_WIN_HI;

  logic busy_q;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_addr_q <= 32'h0;
    end else if (req_in && !busy_q && hit_io && req_wr_in &&
                 io_ofs == `BDSN_IO_ADDR_OFS && req_be_in == 4'hf) begin
      io_addr_q <= req_wdata_in & `BDSN_IO_ADDR_MASK;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      io_addr_out <= 32'h0;
    end else begin
      io_addr_out <= io_addr_q;
    end
  end

  // one request in flight; the core must hold off new ones until the answer
  logic         take;
  logic         fwd;
  bdsn_target_t fwd_target;
  logic [23:0]  fwd_addr;
  logic [31:0]  local_rdata;
  logic         done;

  assign take = req_in && !busy_q;
  assign done = busy_q && int_done_in;

  // priority is bar0, bar1, the expansion rom, then bar3, the i/o window last
  always_comb begin
    fwd        = 1'b0;
    fwd_target = BDSN_TGT_NONE;
    fwd_addr   = 24'h0;
    if (hit_regs) begin
      fwd        = 1'b1;
      fwd_target = BDSN_TGT_REGS;
      fwd_addr   = ofs_regs[23:0];
    end else if (hit_flash) begin
      fwd        = 1'b1;
      fwd_target = BDSN_TGT_FLASH;
      fwd_addr   = ofs_flash[23:0];
    end else if (hit_rom) begin
      fwd        = 1'b1;
      fwd_target = BDSN_TGT_FLASH;
      fwd_addr   = ofs_rom[23:0];
    end else if (hit_msix) begin
      fwd        = 1'b1;
      fwd_target = BDSN_TGT_MSIX;
      fwd_addr   = ofs_msix[23:0];
    end else if (hit_io && io_ofs == `BDSN_IO_DATA_OFS && io_to_flash) begin
      // flash sits in the upper half of the indirect range, rebased to zero
      fwd        = 1'b1;
      fwd_target = BDSN_TGT_FLASH;
      fwd_addr   = {4'h0, io_addr_q[19:0] - `BDSN_FLASH_WIN_LO};
    end else if (hit_io && io_ofs == `BDSN_IO_DATA_OFS && io_to_regs &&
                 (!req_wr_in || req_be_in == 4'hf)) begin
      // partial writes to registers are dropped, never merged
      fwd        = 1'b1;
      fwd_target = BDSN_TGT_REGS;
      fwd_addr   = {7'h0, io_addr_q[16:0]};
    end
  end

  // the block's own answers; undefined indirect range reads as zero
  always_comb begin
    local_rdata = 32'h0;
    if (hit_io && !req_wr_in) begin
      if (io_ofs == `BDSN_IO_ADDR_OFS) begin
        local_rdata = io_addr_q;
      end else if (io_ofs != `BDSN_IO_DATA_OFS) begin
        local_rdata = `BDSN_IO_RSVD_DATA;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_q <= 1'b0;
    end else if (done) begin
      busy_q <= 1'b0;
    end else if (take && fwd) begin
      busy_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_req_out <= 1'b0;
    end else begin
      int_req_out <= take && fwd;
    end
  end

  // held until the next request so the far side may sample them late
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      int_wr_out     <= 1'b0;
      int_target_out <= BDSN_TGT_NONE;
      int_addr_out   <= 24'h0;
      int_be_out     <= 4'h0;
      int_wdata_out  <= 32'h0;
    end else if (take) begin
      int_wr_out    <= req_wr_in;
      int_be_out    <= req_be_in;
      int_wdata_out <= req_wdata_in;
      if (fwd) begin
        int_target_out <= fwd_target;
        int_addr_out   <= fwd_addr;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsp_valid_out <= 1'b0;
      rsp_hit_out   <= 1'b0;
      rsp_rdata_out <= 32'h0;
    end else begin
      rsp_valid_out <= done || (take && !fwd);
      if (done) begin
        rsp_hit_out   <= 1'b1;
        rsp_rdata_out <= int_wr_out ? 32'h0 : int_rdata_in;
      end else if (take && !fwd) begin
        // a miss leaves hit low so the core can report it unclaimed
        rsp_hit_out   <= hit_io;
        rsp_rdata_out <= local_rdata;
      end
    end
  end

endmodule

// File: test/bdsn_checker.sv
// port assertions for the bar decode and serial number block
// assumes a bind onto the design top and a single clock domain
`timescale 1ns/10ps
module bdsn_checker
#(
  parameter logic [23:0] COMPANY_ID = 24'h12_34_56
) (
  // clock, reset, enables
  input wire logic        clock_in,
  input wire logic        rst_b_in,
  input wire logic        io_enable_in,
  input wire logic        nvm_load_done_in,
  // config, host and internal sides
  input wire logic        cfg_rd_in,
  input wire logic [11:0] cfg_ofs_in,
  input wire logic        cfg_valid_out,
  input wire logic [31:0] cfg_data_out,
  input wire logic        req_in,
  input wire logic        req_io_in,
  input wire logic        rsp_valid_out,
  input wire logic        rsp_hit_out,
  input wire logic        int_req_out,
  input wire logic        int_done_in
);
  logic seen_q;
  // label bytes only mean something once the serial is latched
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in) seen_q <= 1'b0;
    else if (nvm_load_done_in) seen_q <= 1'b1;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  a_cfg_one_cycle: assert property (cfg_rd_in |=> cfg_valid_out)
    else $error("config answer late");
  a_hdr_ident: assert property (cfg_rd_in && cfg_ofs_in == 12'h000 |=> cfg_data_out[15:0] == 16'h0003)
    else $error("header id wrong");
  a_hdr_version: assert property (cfg_rd_in && cfg_ofs_in == 12'h000 |=> cfg_data_out[19:16] == 4'h1)
    else $error("header version wrong");
  a_hdr_next: assert property (cfg_rd_in && cfg_ofs_in == 12'h000 |=> cfg_data_out[31:20] == 12'h000 || cfg_data_out[31:20] > 12'h0ff)
    else $error("next offset illegal");
  a_label_ones: assert property (seen_q && cfg_rd_in && cfg_ofs_in == 12'h004 |=> cfg_data_out[31:24] == 8'hff)
    else $error("label byte wrong");
  a_fwd_after_take: assert property (int_req_out |-> $past(req_in))
    else $error("forward without request");
  a_rsp_after_done: assert property (int_done_in |=> rsp_valid_out)
    else $error("answer not after done");
  a_io_gated: assert property (req_in && req_io_in && !io_enable_in |=> rsp_valid_out && !rsp_hit_out && !int_req_out)
    else $error("io decoded while off");
  a_company_id: assert property (seen_q && cfg_rd_in && cfg_ofs_in == 12'h008 |=> cfg_data_out[31:8] == COMPANY_ID)
    else $error("company id wrong");
  a_label_high: assert property (seen_q && cfg_rd_in && cfg_ofs_in == 12'h008 |=> cfg_data_out[7:0] == 8'hff)
    else $error("upper label byte wrong");
endmodule
bind bdsn_bar_decode bdsn_checker #(
  .COMPANY_ID(COMPANY_ID)
) bdsn_checker_inst (
  .clock_in        (clock_in),
  .rst_b_in        (rst_b_in),
  .io_enable_in    (io_enable_in),
  .nvm_load_done_in(nvm_load_done_in),
  .cfg_rd_in       (cfg_rd_in),
  .cfg_ofs_in      (cfg_ofs_in),
  .cfg_valid_out   (cfg_valid_out),
  .cfg_data_out    (cfg_data_out),
  .req_in          (req_in),
  .req_io_in       (req_io_in),
  .rsp_valid_out   (rsp_valid_out),
  .rsp_hit_out     (rsp_hit_out),
  .int_req_out     (int_req_out),
  .int_done_in     (int_done_in)
);

// File: test/bdsn_int_partner.sv
// responder on the internal access port of the block
// assumes at most one internal request outstanding
`timescale 1ns/10ps
module bdsn_int_partner (
  // from the block and the bench
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  input  wire logic        int_req_out,
  input  wire logic [23:0] int_addr_out,
  input  wire logic        slow_in,
  // answers
  output logic             int_done_in,
  output logic [31:0]      int_rdata_in
);
  logic       busy_q;
  logic [2:0] wait_q;
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in) {busy_q, wait_q} <= 4'h0;
    else if (int_req_out) {busy_q, wait_q} <= {1'b1, slow_in ? 3'h5 : 3'h0};
    else if (wait_q != 3'h0) wait_q <= wait_q - 3'h1;
    else busy_q <= 1'b0;
  assign int_done_in = busy_q && wait_q == 3'h0;
  // inverted outside done so a stale capture cannot match
  assign int_rdata_in = int_done_in ? {8'h5a, int_addr_out} : ~{8'h5a, int_addr_out};
endmodule

// File: test/bdsn_bar_decode_bench.sv
// self-checking bench for the bar decode and serial number block
// assumes the internal port responder and the bound checker
`timescale 1ns/10ps
module bdsn_bar_decode_bench;
  import bdsn_pkg::*;
  localparam logic [23:0] CID = 24'h0a_0b_0c; // arbitrary value
  logic clock_in = 0, rst_b_in = 0, cfg_rd_in = 0, req_in = 0, req_io_in = 0, req_wr_in = 0;
  logic io_enable_in = 0, flash_enable_in = 0, rom_enable_in = 0, nvm_load_done_in = 0, slow_in = 0;
  logic [31:0] bar0_in = 32'h1000_0000, bar1_in = 32'h2000_0000, bar2_in = 32'h0000_e000;
  logic [31:0] bar3_in = 32'h4000_0000, rom_bar_in = 32'h3000_0000, req_addr_in = 0, req_wdata_in = 0;
  logic [31:0] receive_address_low_in = 32'h4433_2211, cfg_data_out, rsp_rdata_out, int_wdata_out;
  logic [31:0] int_rdata_in, io_addr_out;
  logic [15:0] receive_address_high_in = 16'h6655;
  logic [11:0] cfg_ofs_in = 0;
  logic [3:0] req_be_in = 4'hf, int_be_out;
  logic cfg_valid_out, rsp_valid_out, rsp_hit_out, int_req_out, int_wr_out, int_done_in;
  logic [23:0] int_addr_out, adr;
  logic [2:0] tgt;
  bdsn_target_t int_target_out;
  int n_mismatch = 0, samples_checked = 0, cyc = 0;
  bdsn_bar_decode #(.COMPANY_ID(CID)) bdsn_bar_decode_inst (.*);
  bdsn_int_partner bdsn_int_partner_inst (.*);
  always #20 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cfg(input logic [11:0] ofs, input logic [31:0] exp);
    @(posedge clock_in) {cfg_rd_in, cfg_ofs_in} <= {1'b1, ofs};
    @(posedge clock_in) cfg_rd_in <= 1'b0;
    #1;
    chk("cfg valid", 32'(cfg_valid_out), 32'h1);
    chk("cfg data", cfg_data_out, exp);
  endtask
  // one host request; fields held until the answer, target seen at the forward pulse
  task automatic acc(input logic io, wr, input logic [31:0] a, wd, input logic [3:0] be,
                     input logic h, input logic [2:0] t, input logic [23:0] ad);
    int i;
    {tgt, adr} = 27'h0;
    @(posedge clock_in) {req_in, req_io_in, req_wr_in, req_addr_in, req_wdata_in, req_be_in} <= {1'b1, io, wr, a, wd, be};
    @(posedge clock_in) req_in <= 1'b0;
    for (i = 0; i < 20; i++) begin
      #1;
      if (int_req_out) {tgt, adr} = {int_target_out, int_addr_out};
      if (rsp_valid_out) break;
      @(posedge clock_in);
    end
    chk("hit", 32'(rsp_hit_out), 32'(h));
    chk("target", 32'(tgt), 32'(t));
    chk("int addr", 32'(adr), 32'(ad));
    if (h && t != 3'h0 && !wr) chk("rdata", rsp_rdata_out, {8'h5a, ad});
    if (wr || !h) chk("zero rdata", rsp_rdata_out, 32'h0);
    if (t != 3'h0) begin
      chk("int wr", 32'(int_wr_out), 32'(wr));
      chk("int be", 32'(int_be_out), 32'(be));
      chk("int wdata", int_wdata_out, wd);
    end
  endtask
  task automatic t_cfg();
    cfg(12'h000, 32'h0001_0003);
    cfg(12'h004, 32'h0);
    @(posedge clock_in) nvm_load_done_in <= 1'b1;
    @(posedge clock_in) nvm_load_done_in <= 1'b0;
    cfg(12'h004, 32'hff44_5566);
    cfg(12'h008, {CID, 8'hff});
    @(posedge clock_in) {receive_address_low_in, receive_address_high_in} <= 48'h0;
    cfg(12'h004, 32'hff44_5566);
    cfg(12'h00c, 32'h0);
    @(posedge clock_in) rst_b_in <= 1'b0;
    @(posedge clock_in) rst_b_in <= 1'b1;
    cfg(12'h004, 32'h0);
    @(posedge clock_in) nvm_load_done_in <= 1'b1;
    @(posedge clock_in) nvm_load_done_in <= 1'b0;
    cfg(12'h004, 32'hff00_0000);
  endtask
  task automatic t_mem();
    acc(0, 0, 32'h1001_fffc, 0, 4'hf, 1, BDSN_TGT_REGS, 24'h01_fffc);
    acc(0, 0, 32'h1002_0000, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
    acc(0, 0, 32'h2012_3450, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
    acc(0, 0, 32'h3000_0100, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
    @(posedge clock_in) {flash_enable_in, rom_enable_in, slow_in} <= 3'h7;
    acc(0, 0, 32'h20ab_cdec, 0, 4'hf, 1, BDSN_TGT_FLASH, 24'hab_cdec);
    acc(0, 0, 32'h3003_fff0, 0, 4'hf, 1, BDSN_TGT_FLASH, 24'h03_fff0);
    acc(0, 1, 32'h4000_3ffc, 1, 4'hf, 1, BDSN_TGT_MSIX, 24'h00_3ffc);
    acc(0, 0, 32'h4000_4000, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
    @(posedge clock_in) bar1_in <= 32'h0;
    acc(0, 0, 32'h0000_0010, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
  endtask
  task automatic t_io();
    acc(1, 0, 32'h0000_e004, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
    @(posedge clock_in) {io_enable_in, slow_in} <= 2'h2;
    acc(1, 1, 32'h0000_e000, 32'hfff8_0123, 4'hf, 1, BDSN_TGT_NONE, 24'h0);
    acc(1, 0, 32'h0000_e000, 0, 4'hf, 1, BDSN_TGT_NONE, 24'h0);
    chk("io address read", rsp_rdata_out, 32'h0008_0123);
    chk("io address", io_addr_out, 32'h0008_0123);
    acc(1, 0, 32'h0000_e004, 0, 4'hf, 1, BDSN_TGT_FLASH, 24'h00_0123);
    acc(1, 1, 32'h0000_e000, 32'h40, 4'h3, 1, BDSN_TGT_NONE, 24'h0);
    acc(1, 0, 32'h0000_e000, 0, 4'hf, 1, BDSN_TGT_NONE, 24'h0);
    chk("io address read", rsp_rdata_out, 32'h0008_0123);
    chk("io address", io_addr_out, 32'h0008_0123);
    acc(1, 1, 32'h0000_e000, 32'h2_0000, 4'hf, 1, BDSN_TGT_NONE, 24'h0);
    acc(1, 0, 32'h0000_e004, 0, 4'hf, 1, BDSN_TGT_NONE, 24'h0);
    chk("undefined", rsp_rdata_out, 32'h0);
    acc(1, 1, 32'h0000_e000, 32'h40, 4'hf, 1, BDSN_TGT_NONE, 24'h0);
    acc(1, 1, 32'h0000_e004, 32'h1234, 4'h3, 1, BDSN_TGT_NONE, 24'h0);
    acc(1, 1, 32'h0000_e004, 32'h1234, 4'hf, 1, BDSN_TGT_REGS, 24'h00_0040);
    acc(1, 0, 32'h0000_e004, 0, 4'hf, 1, BDSN_TGT_REGS, 24'h00_0040);
    acc(1, 0, 32'h0000_e008, 0, 4'hf, 1, BDSN_TGT_NONE, 24'h0);
    chk("reserved", rsp_rdata_out, 32'h0000_ffff);
    acc(1, 0, 32'h0000_e020, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
    @(posedge clock_in) bar2_in <= 32'h0;
    acc(1, 0, 32'h0000_0004, 0, 4'hf, 0, BDSN_TGT_NONE, 24'h0);
  endtask
  initial begin
    repeat (8) @(posedge clock_in);
    rst_b_in <= 1'b1;
    t_cfg();
    t_mem();
    t_io();
    report_and_stop();
  end
endmodule
